//--- rtl/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level.
`timescale 1ns/1ps

module pin_sync
#(
    parameter int unsigned WIDTH = 1
)
(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pinAsync,
    output logic      [WIDTH-1:0] pinSync
);

    logic [WIDTH-1:0] stage1_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage1_q <= '0;
            pinSync  <= '0;
        end
        else
        begin
            stage1_q <= pinAsync;
            pinSync  <= stage1_q;
        end
    end

endmodule : pin_sync

//--- rtl/spi_register_slave_port.sv
// Serial register-access slave port with identification, revision,
// write guard and two configuration registers.
// Assumes an external master drives chip select, serial clock and data.
`timescale 1ns/1ps

// Functional notes
// - Access only while chip select low; clock and data ignored when high.
// - Master-to-device data arrives on serial input, sampled by device.
// - Device returns data to the master on serial output.
// - Serial output driver can be released to high impedance.
// - Clock phase 0 latches on leading edge, 1 on trailing edge.
// - Clock polarity 0 idles low, 1 idles high.
// - Sixteen-bit identification split over two read-only registers.
// - A register returns the silicon revision value.
// - Write guard register blocks writes to the two configuration registers.
// - Reset returns port and registers to defaults while asserted.
module spi_register_slave_port
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic csN,
    input  wire logic sclk,
    input  wire logic sdi,
    input  wire logic cpha,
    input  wire logic cpol,
    output logic      sdoOut,
    output logic      sdoOe,
    output logic [7:0] configA,
    output logic [7:0] configB,
    output logic [7:0] writeGuard,
    output logic      writeRefused
);
    import spi_slave_pkg::*;

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        port_state_t state;
        logic        sclkPrev;
        logic [4:0]  bitCnt;
        logic [14:0] shiftIn;
        logic        isRead;
        logic [7:0]  txReg;
        logic        sdo;
        logic        sdoOe;
        logic [7:0]  guard;
        logic [7:0]  cfgA;
        logic [7:0]  cfgB;
        logic        refused;
    } port_regs_t;

    localparam port_regs_t REGS_RESET = '{
        state:    ST_IDLE,
        sclkPrev: 1'b0,
        bitCnt:   5'h00,
        shiftIn:  15'h0000,
        isRead:   1'b0,
        txReg:    8'h00,
        sdo:      1'b0,
        sdoOe:    1'b0,
        guard:    GUARD_RESET,
        cfgA:     CONFIG_RESET,
        cfgB:     CONFIG_RESET,
        refused:  1'b0
    };

    port_regs_t regs_q;
    port_regs_t regs_d;

    logic [PIN_COUNT-1:0] pinsRaw;
    logic [PIN_COUNT-1:0] pinsSync;

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    assign pinsRaw = {cpol, cpha, sdi, sclk, csN};

    pin_sync
    #(
        .WIDTH    (PIN_COUNT)
    )
    u_pin_sync
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .pinAsync (pinsRaw),
        .pinSync  (pinsSync)
    );

    // -------------------------------------------------------------------
    // Read multiplexer
    // -------------------------------------------------------------------
    function automatic logic [7:0] read_reg
    (
        input logic [6:0] addr,
        input logic [7:0] guard,
        input logic [7:0] cfgA,
        input logic [7:0] cfgB
    );
        logic [7:0] val;
        case (addr)
            ADDR_IDENT_UPPER: val = IDENT_CODE[15:8];
            ADDR_IDENT_LOWER: val = IDENT_CODE[7:0];
            ADDR_REVISION:    val = REVISION_CODE;
            ADDR_WRITE_GUARD: val = guard;
            ADDR_CONFIG_A:    val = cfgA;
            ADDR_CONFIG_B:    val = cfgB;
            default:          val = READ_UNMAPPED;
        endcase
        return val;
    endfunction : read_reg

    // -------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------
    logic       sclkNow;
    logic       sdiNow;
    logic       riseEdge;
    logic       fallEdge;
    logic       leadEdge;
    logic       trailEdge;
    logic       sampleEdge;
    logic       shiftEdge;
    logic [7:0] cmdByte;
    logic [7:0] dataByte;

    // Edge finding on the sampled serial clock
    always_comb
    begin
        sclkNow   = pinsSync[PIN_SCLK];
        sdiNow    = pinsSync[PIN_SDI];
        riseEdge  = sclkNow & ~regs_q.sclkPrev;
        fallEdge  = ~sclkNow & regs_q.sclkPrev;
        leadEdge  = pinsSync[PIN_CPOL] ? fallEdge : riseEdge;
        trailEdge = pinsSync[PIN_CPOL] ? riseEdge : fallEdge;
        sampleEdge = pinsSync[PIN_CPHA] ? trailEdge : leadEdge;
        shiftEdge  = pinsSync[PIN_CPHA] ? leadEdge : trailEdge;
        cmdByte   = {regs_q.shiftIn[6:0], sdiNow};
        dataByte  = {regs_q.shiftIn[6:0], sdiNow};
    end

    // Frame sequencing, register access and output drive
    always_comb
    begin
        regs_d          = regs_q;
        regs_d.sclkPrev = sclkNow;
        regs_d.refused  = 1'b0;
        if (pinsSync[PIN_CSN])
        begin
            // Deselected: abandon frame, release output
            regs_d.state  = ST_IDLE;
            regs_d.bitCnt = 5'h00;
            regs_d.sdoOe  = 1'b0;
            regs_d.sdo    = 1'b0;
        end
        else
        begin
            case (regs_q.state)
                ST_IDLE:
                begin
                    regs_d.state  = ST_CMD;
                    regs_d.bitCnt = 5'h00;
                    regs_d.isRead = 1'b0;
                end
                ST_CMD:
                begin
                    if (sampleEdge)
                    begin
                        regs_d.shiftIn = {regs_q.shiftIn[13:0], sdiNow};
                        regs_d.bitCnt  = regs_q.bitCnt + 5'h01;
                        if (regs_q.bitCnt == CMD_LAST)
                        begin
                            regs_d.state  = ST_DATA;
                            regs_d.isRead = cmdByte[RW_POS];
                            regs_d.txReg  = read_reg(cmdByte[6:0],
                                regs_q.guard, regs_q.cfgA, regs_q.cfgB);
                        end
                    end
                end
                ST_DATA:
                begin
                    if (shiftEdge && regs_q.isRead)
                    begin
                        // Present next read bit, MSB first
                        regs_d.sdoOe = 1'b1;
                        regs_d.sdo   = regs_q.txReg[7];
                        regs_d.txReg = {regs_q.txReg[6:0], 1'b0};
                    end
                    if (sampleEdge)
                    begin
                        regs_d.shiftIn = {regs_q.shiftIn[13:0], sdiNow};
                        regs_d.bitCnt  = regs_q.bitCnt + 5'h01;
                        if (regs_q.bitCnt == DATA_LAST)
                        begin
                            regs_d.state = ST_DONE;
                            if (!regs_q.isRead)
                            begin
                                case (regs_q.shiftIn[13:7])
                                    ADDR_WRITE_GUARD:
                                        regs_d.guard = dataByte;
                                    ADDR_CONFIG_A:
                                    begin
                                        if (regs_q.guard == GUARD_OPEN)
                                            regs_d.cfgA = dataByte;
                                        else
                                            regs_d.refused = 1'b1;
                                    end
                                    ADDR_CONFIG_B:
                                    begin
                                        if (regs_q.guard == GUARD_OPEN)
                                            regs_d.cfgB = dataByte;
                                        else
                                            regs_d.refused = 1'b1;
                                    end
                                    // Identity and revision ignore writes
                                    default:
                                        regs_d.refused = 1'b0;
                                endcase
                            end
                        end
                    end
                end
                ST_DONE:
                begin
                    // Extra clocks ignored until deselect
                    regs_d.state = ST_DONE;
                end
                default:
                begin
                    regs_d.state = ST_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            regs_q <= REGS_RESET;
        else
            regs_q <= regs_d;
    end

    // Outputs straight from flops
    assign sdoOut       = regs_q.sdo;
    assign sdoOe        = regs_q.sdoOe;
    assign configA      = regs_q.cfgA;
    assign configB      = regs_q.cfgB;
    assign writeGuard   = regs_q.guard;
    assign writeRefused = regs_q.refused;

endmodule : spi_register_slave_port

//--- rtl/spi_slave_pkg.sv
// Constants for the serial register-access slave port.
// Assumes a 50 MHz core clock and an 8-bit register set.
package spi_slave_pkg;

    // -------------------------------------------------------------------
    // Frame layout
    // -------------------------------------------------------------------
    localparam int unsigned FRAME_BITS = 16;   // Command byte then data
    localparam logic [4:0]  CMD_LAST   = 5'h07; // Count before 8th bit
    localparam logic [4:0]  DATA_LAST  = 5'h0F; // Count before 16th bit
    localparam int unsigned RW_POS     = 7;    // Bit 7 of command: 1=read

    // -------------------------------------------------------------------
    // Register offsets (7-bit address)
    // -------------------------------------------------------------------
    localparam logic [6:0] ADDR_IDENT_UPPER = 7'h00;
    localparam logic [6:0] ADDR_IDENT_LOWER = 7'h01;
    localparam logic [6:0] ADDR_REVISION    = 7'h02;
    localparam logic [6:0] ADDR_WRITE_GUARD = 7'h03;
    localparam logic [6:0] ADDR_CONFIG_A    = 7'h04;
    localparam logic [6:0] ADDR_CONFIG_B    = 7'h05;

    // -------------------------------------------------------------------
    // Values
    // -------------------------------------------------------------------
    localparam logic [15:0] IDENT_CODE    = 16'h5A3C; // Arbitrary value
    localparam logic [7:0]  REVISION_CODE = 8'h01;    // Arbitrary value
    localparam logic [7:0]  GUARD_OPEN    = 8'h00;    // Writes allowed
    localparam logic [7:0]  GUARD_RESET   = 8'h00;
    localparam logic [7:0]  CONFIG_RESET  = 8'h00;
    localparam logic [7:0]  READ_UNMAPPED = 8'h00;

    // -------------------------------------------------------------------
    // Pin vector positions after synchronising
    // -------------------------------------------------------------------
    localparam int unsigned PIN_COUNT = 5;
    localparam int unsigned PIN_CSN   = 0;
    localparam int unsigned PIN_SCLK  = 1;
    localparam int unsigned PIN_SDI   = 2;
    localparam int unsigned PIN_CPHA  = 3;
    localparam int unsigned PIN_CPOL  = 4;

    typedef enum logic [3:0]
    {
        ST_IDLE = 4'h1,
        ST_CMD  = 4'h2,
        ST_DATA = 4'h4,
        ST_DONE = 4'h8
    } port_state_t;

endpackage : spi_slave_pkg

//--- tb/spi_master_model.sv
// Serial bus master model that frames register accesses.
// Assumes clk is the core clock; pins change on its falling edge.
`timescale 1ns/1ps
module spi_master_model
(
    input  wire logic clk,
    input  wire logic cpol,
    input  wire logic cpha,
    input  wire logic sdo,
    output logic      csN,
    output logic      sclk,
    output logic      sdi
);
    // Idle pins
    initial
    begin
        csN  = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end
    // One 16-bit frame; sel low keeps chip select high throughout
    task automatic xfer(input logic [15:0] tx, input logic sel,
                        output logic [7:0] rx);
        rx   = 8'h00;
        sclk = cpol;
        repeat (4) @(negedge clk);
        csN = ~sel;
        for (int i = 15; i >= 0; i--)
        begin
            if (!cpha) sdi = tx[i];
            repeat (4) @(negedge clk);
            sclk = ~cpol;
            if (cpha) sdi = tx[i];
            else rx = {rx[6:0], sdo};
            repeat (4) @(negedge clk);
            sclk = cpol;
            if (cpha) rx = {rx[6:0], sdo};
        end
        repeat (4) @(negedge clk);
        csN = 1'b1;
        sdi = ~sdi; // Released line inverts its last value
        repeat (4) @(negedge clk);
    endtask : xfer
endmodule : spi_master_model

//--- tb/spi_port_chk.sv
// Assertions on the serial register slave port pins.
// Assumes the bind at the foot of this file reaches every port instance.
`timescale 1ns/1ps
module spi_port_chk
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       csN,
    input wire logic       sclk,
    input wire logic       sdi,
    input wire logic       cpha,
    input wire logic       cpol,
    input wire logic       sdoOut,
    input wire logic       sdoOe,
    input wire logic [7:0] configA,
    input wire logic [7:0] configB,
    input wire logic [7:0] writeGuard,
    input wire logic       writeRefused
);
    import spi_slave_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Output release and register hold while deselected
    AST_OE_DESEL: assert property (csN [*5] |-> !sdoOe)
        else $error("output driven while deselected");
    AST_HOLD_DESEL: assert property (csN [*6] |->
        $stable({configA, configB, writeGuard}))
        else $error("register changed while deselected");
    AST_OE_SEL: assert property ($rose(sdoOe) |->
        !csN && $past(csN, 4) == 1'b0)
        else $error("output enabled outside a frame");
    // Write guard effects
    AST_REFUSE_GUARD: assert property (
        writeRefused |-> writeGuard != GUARD_OPEN)
        else $error("refusal with guard open");
    AST_REFUSE_PULSE: assert property (
        writeRefused |=> !writeRefused)
        else $error("refusal pulse too long");
    AST_GUARD_A: assert property (
        $changed(configA) |-> $past(writeGuard) == GUARD_OPEN)
        else $error("config A written while guarded");
    AST_GUARD_B: assert property (
        $changed(configB) |-> $past(writeGuard) == GUARD_OPEN)
        else $error("config B written while guarded");
    // Defaults seen right after reset
    AST_RESET_VAL: assert property ($fell(sys_rst) |->
        configA == CONFIG_RESET && configB == CONFIG_RESET &&
        writeGuard == GUARD_RESET && !sdoOe && !writeRefused)
        else $error("register not at default after reset");
    // Read bits move only three clocks after a shift edge of the pin
    AST_SDO_SHIFT: assert property (
        sdoOe && ($changed(sdoOut) || $rose(sdoOe)) |->
        $past(sclk, 3) == (cpol ^ cpha) && $past(sclk, 4) != (cpol ^ cpha))
        else $error("read bit moved off the shift edge");
endmodule : spi_port_chk

bind spi_register_slave_port spi_port_chk chk
(
    .clk(clk), .sys_rst(sys_rst), .csN(csN), .sclk(sclk), .sdi(sdi),
    .cpha(cpha), .cpol(cpol), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .configA(configA), .configB(configB), .writeGuard(writeGuard),
    .writeRefused(writeRefused)
);

//--- tb/tb.sv
// Self-checking bench for the serial register slave port.
// Assumes the package, design, checker and master model are compiled.
`timescale 1ns/1ps
module tb;
    import spi_slave_pkg::*;
    logic       clk, sys_rst, cpha, cpol, sdoOut, sdoOe;
    logic       csN, sclk, sdi, writeRefused;
    logic [7:0] configA, configB, writeGuard, rxByte;
    int         mismatches = 0;
    int         totalChecks = 0;
    int         refusedCount = 0;
    wire        sdoWire = sdoOe ? sdoOut : 1'bz;

    spi_register_slave_port dut
    (
        .clk(clk), .sys_rst(sys_rst), .csN(csN), .sclk(sclk), .sdi(sdi),
        .cpha(cpha), .cpol(cpol), .sdoOut(sdoOut), .sdoOe(sdoOe),
        .configA(configA), .configB(configB), .writeGuard(writeGuard),
        .writeRefused(writeRefused)
    );
    spi_master_model master
    (
        .clk(clk), .cpol(cpol), .cpha(cpha), .sdo(sdoWire),
        .csN(csN), .sclk(sclk), .sdi(sdi)
    );

    // Compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // Register accesses
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        master.xfer({1'b0, a, d}, 1'b1, rxByte);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        master.xfer({1'b1, a, 8'h00}, 1'b1, rxByte);
        check(rxByte, e);
    endtask : rd
    // Verdict
    task automatic wrapUp;
        if (mismatches == 0 && totalChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrapUp

    // Clock, watchdog and refusal monitor
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        #400000;
        mismatches++;
        wrapUp();
    end
    // Count refusal pulses; one process owns the counter
    always @(posedge clk)
        if (writeRefused === 1'b1) refusedCount <= refusedCount + 1;

    // Test sequence
    initial
    begin
        sys_rst     = 1'b1;
        cpha        = 1'b0;
        cpol        = 1'b0;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk);
        for (int m = 0; m < 4; m++)
        begin
            {cpol, cpha} = m[1:0];
            wr(ADDR_CONFIG_A, 8'hA5 ^ m[7:0]);
            check(configA, 8'hA5 ^ m[7:0]);
            master.xfer({1'b0, ADDR_CONFIG_A, 8'h3C}, 1'b0, rxByte);
            check(configA, 8'hA5 ^ m[7:0]);
            rd(ADDR_CONFIG_A, 8'hA5 ^ m[7:0]);
            rd(ADDR_IDENT_UPPER, IDENT_CODE[15:8]);
            rd(ADDR_IDENT_LOWER, IDENT_CODE[7:0]);
            rd(ADDR_REVISION, REVISION_CODE);
        end
        wr(ADDR_IDENT_UPPER, 8'hFF);
        rd(ADDR_IDENT_UPPER, IDENT_CODE[15:8]);
        rd(7'h7F, READ_UNMAPPED);
        check(8'(refusedCount), 8'h00);
        wr(ADDR_WRITE_GUARD, 8'h01);
        check(writeGuard, 8'h01);
        wr(ADDR_CONFIG_B, 8'h66);
        check(configB, CONFIG_RESET);
        check(8'(refusedCount), 8'h01);
        wr(ADDR_WRITE_GUARD, GUARD_OPEN);
        wr(ADDR_CONFIG_B, 8'h66);
        check(configB, 8'h66);
        check(8'(refusedCount), 8'h01);
        sys_rst = 1'b1;
        @(negedge clk);
        check(configB, CONFIG_RESET);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk);
        rd(ADDR_CONFIG_B, CONFIG_RESET);
        wrapUp();
    end
endmodule : tb
